// >>> rtl/rsc_pkg.sv
// Constants, encodings and timing shared by the reset/strap sequencer ends.
// Assumes one 100 MHz clock on both ends and a link that joins them.
//
// Overview of operation
// - Low reset input holds device in reset.
// - Other party holds reset low 2 ms.
// - Host waits 125 ms or polls ready.
// - Status bit 7 at 0x000 flags ready.
// - Pins 0,1,3 strap; pin 3 host mode.
// - Other party holds straps 125 ms, releases.
// - Other party keeps pin 4 low 125 ms.
// - Pins 5 and 6 carry no strap.
// - Every pin takes a selectable run-time function.
package rsc_pkg;

   // --------------------
   // Timing
   // --------------------
   localparam int CLK_HZ          = 100_000_000;
   localparam int CYC_PER_MS      = CLK_HZ / 1000;
   localparam int RST_HOLD_MS     = 2;
   localparam int ACCESS_WAIT_MS  = 125;
   localparam int CFG_SAMPLE_MS   = 100;
   localparam int RST_HOLD_CYC    = RST_HOLD_MS * CYC_PER_MS;
   localparam int ACCESS_WAIT_CYC = ACCESS_WAIT_MS * CYC_PER_MS;
   localparam int CFG_SAMPLE_CYC  = CFG_SAMPLE_MS * CYC_PER_MS;

   // --------------------
   // Pins and straps
   // --------------------
   localparam int         GPIO_N    = 7;
   localparam int         PIN_RATE0 = 0;
   localparam int         PIN_RATE1 = 1;
   localparam int         PIN_MODE  = 3;
   localparam int         PIN_LOW   = 4;
   localparam logic [6:0] GPIO_PULL = 7'h40;

   // --------------------
   // Device registers
   // --------------------
   localparam int         REG_AW       = 9;
   localparam int         REG_DW       = 8;
   localparam logic [8:0] REG_STATUS   = 9'h000;
   localparam logic [8:0] REG_FN_BASE  = 9'h010;
   localparam int         READY_BIT    = 7;
   localparam int         IRQ_BIT      = 6;
   localparam int         MODE_BIT     = 2;
   localparam int         RATE_LSB     = 0;
   localparam int         FN_W         = 3;

   // --------------------
   // Host control registers (Avalon byte addresses)
   // --------------------
   localparam int         AV_AW      = 4;
   localparam logic [3:0] AV_CTRL    = 4'h0;
   localparam logic [3:0] AV_STATUS  = 4'h4;
   localparam logic [3:0] AV_DEVCMD  = 4'h8;
   localparam logic [3:0] AV_DEVDATA = 4'hc;
   localparam int         CTRL_START = 0;
   localparam int         CTRL_RATE  = 1;
   localparam int         CTRL_MODE  = 3;
   localparam int         ST_READY   = 3;
   localparam int         ST_GPIO    = 4;
   localparam int         CMD_ADDR   = 8;
   localparam int         CMD_WR     = 24;
   localparam int         DATA_DONE  = 8;

   // --------------------
   // Encodings
   // --------------------
   typedef enum logic [2:0] {
      FN_INPUT    = 3'h0,
      FN_LOCK     = 3'h1,
      FN_HOLDOVER = 3'h2,
      FN_REF_FAIL = 3'h3,
      FN_REF_SEL  = 3'h4,
      FN_OUT_EN   = 3'h5,
      FN_IRQ      = 3'h6
   } rsc_fn_type;

   typedef enum logic [1:0] {
      DEV_RESET  = 2'h0,
      DEV_CONFIG = 2'h1,
      DEV_READY  = 2'h2
   } rsc_dev_state_type;

   typedef enum logic [2:0] {
      H_IDLE     = 3'h0,
      H_RESET    = 3'h1,
      H_STRAP    = 3'h2,
      H_POLL     = 3'h3,
      H_POLL_ACK = 3'h4,
      H_READY    = 3'h5,
      H_CMD_ACK  = 3'h6
   } rsc_host_state_type;

endpackage

// >>> rtl/rsc_if.sv
// Link between the board-side sequencer and the strapped device.
// Resolves each general pin from both enables and its internal pull.
`timescale 1ns/1ps
`default_nettype none
interface rsc_if;
   import rsc_pkg::*;

   logic                 por_n;
   logic [GPIO_N-1:0]    gpio_dev_o;
   logic [GPIO_N-1:0]    gpio_dev_oe;
   logic [GPIO_N-1:0]    gpio_host_o;
   logic [GPIO_N-1:0]    gpio_host_oe;
   logic [GPIO_N-1:0]    gpio_level;
   logic                 reg_req;
   logic                 reg_wr;
   logic [REG_AW-1:0]    reg_addr;
   logic [REG_DW-1:0]    reg_wdata;
   logic                 reg_ack;
   logic [REG_DW-1:0]    reg_rdata;

   // Device drive wins, then host drive, then the pull
   assign gpio_level = (gpio_dev_oe & gpio_dev_o)
                     | (~gpio_dev_oe & gpio_host_oe & gpio_host_o)
                     | (~gpio_dev_oe & ~gpio_host_oe & GPIO_PULL);

   modport dev (input por_n, gpio_level, reg_req, reg_wr, reg_addr, reg_wdata,
                output gpio_dev_o, gpio_dev_oe, reg_ack, reg_rdata);
   modport host (input gpio_level, reg_ack, reg_rdata,
                 output por_n, gpio_host_o, gpio_host_oe, reg_req, reg_wr,
                 reg_addr, reg_wdata);
endinterface
`default_nettype wire

// >>> rtl/rsc_device.sv
// Device end: power-on reset, strap capture, ready flag, pin functions.
// Assumes reset and pins arrive asynchronously; register port is on mclk.
`timescale 1ns/1ps
`default_nettype none
module rsc_device
   import rsc_pkg::*;
#(
   parameter int CFG_SAMPLE_CYCLES = CFG_SAMPLE_CYC
)
(
   // Clock, reset, enable
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   // Link
   rsc_if.dev              link,
   // Loop status from the core
   input  wire logic       dpll_lock,
   input  wire logic       dpll_holdover,
   input  wire logic       ref_fail,
   input  wire logic       ref_sel,
   input  wire logic       status_change,
   // Configuration and control towards the core
   output logic            host_mode_spi,
   output logic [1:0]      clk_rate_sel,
   output logic            dev_ready,
   output logic            out_enable
);

   // --------------------
   // Input synchronisers
   // --------------------
   logic              por_s1_q;
   logic              por_s2_q;
   logic [GPIO_N-1:0] pin_s1_q;
   logic [GPIO_N-1:0] pin_s2_q;

   // Second stage only is read by logic
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         por_s1_q <= 1'b0;
         por_s2_q <= 1'b0;
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end
      else if (ce)
      begin
         por_s1_q <= link.por_n;
         por_s2_q <= por_s1_q;
         pin_s1_q <= link.gpio_level;
         pin_s2_q <= pin_s1_q;
      end
   end

   // --------------------
   // State
   // --------------------
   rsc_dev_state_type state_q, state_d;
   logic [31:0]       cnt_q, cnt_d;
   logic              mode_q, mode_d;
   logic [1:0]        rate_q, rate_d;
   logic              irq_q, irq_d;
   logic              ack_q, ack_d;
   logic [REG_DW-1:0] rdata_q, rdata_d;
   logic              oen_q, oen_d;
   rsc_fn_type        fn_q [GPIO_N];
   rsc_fn_type        fn_d [GPIO_N];
   logic [GPIO_N-1:0] pin_o_q, pin_o_d;
   logic [GPIO_N-1:0] pin_oe_q, pin_oe_d;

   // Register index decode, shared by read and write paths
   function automatic logic fn_hit(input logic [REG_AW-1:0] a, input int i);
      fn_hit = (a == REG_FN_BASE + REG_AW'(i));
   endfunction

   function automatic logic [REG_DW-1:0] status_byte(input logic rdy,
                                                     input logic irq,
                                                     input logic mode,
                                                     input logic [1:0] rate);
      status_byte = '0;
      status_byte[READY_BIT]        = rdy;
      status_byte[IRQ_BIT]          = irq;
      status_byte[MODE_BIT]         = mode;
      status_byte[RATE_LSB +: 2]    = rate;
   endfunction

   // Next-state logic
   always_comb
   begin
      logic ready;
      logic st_rd;
      ready    = (state_q == DEV_READY);
      st_rd    = 1'b0;
      state_d  = state_q;
      cnt_d    = cnt_q;
      mode_d   = mode_q;
      rate_d   = rate_q;
      irq_d    = irq_q;
      ack_d    = 1'b0;
      rdata_d  = rdata_q;
      oen_d    = 1'b0;
      fn_d     = fn_q;
      pin_o_d  = '0;
      pin_oe_d = '0;

      // Power-up sequence
      case (state_q)
         DEV_RESET:
         begin
            cnt_d = '0;
            if (por_s2_q)
               state_d = DEV_CONFIG;
         end
         DEV_CONFIG:
         begin
            cnt_d = cnt_q + 32'h1;
            // One-time capture; pins 4..6 never steer configuration
            if (cnt_q == 32'(CFG_SAMPLE_CYCLES - 1))
            begin
               mode_d  = pin_s2_q[PIN_MODE];
               rate_d  = {pin_s2_q[PIN_RATE1], pin_s2_q[PIN_RATE0]};
               state_d = DEV_READY;
            end
         end
         DEV_READY:
            state_d = DEV_READY;
         default:
            state_d = DEV_RESET;
      endcase

      // Register port answers one cycle after each request
      if (link.reg_req)
      begin
         ack_d   = 1'b1;
         rdata_d = '0;
         if (link.reg_addr == REG_STATUS)
         begin
            rdata_d = status_byte(ready, irq_q, mode_q, rate_q);
            st_rd   = !link.reg_wr;
         end
         else
         begin
            for (int i = 0; i < GPIO_N; i++)
            begin
               if (fn_hit(link.reg_addr, i))
               begin
                  rdata_d = REG_DW'(fn_q[i]);
                  if (link.reg_wr && ready)
                     fn_d[i] = rsc_fn_type'(link.reg_wdata[FN_W-1:0]);
               end
            end
         end
      end

      // Sticky change flag: a new event beats the clearing read
      if (st_rd)
         irq_d = 1'b0;
      if (ready && status_change)
         irq_d = 1'b1;

      // Pins stay released until configuration is over
      for (int i = 0; i < GPIO_N; i++)
      begin
         if (ready)
         begin
            case (fn_q[i])
               FN_LOCK:     pin_o_d[i] = dpll_lock;
               FN_HOLDOVER: pin_o_d[i] = dpll_holdover;
               FN_REF_FAIL: pin_o_d[i] = ref_fail;
               FN_REF_SEL:  pin_o_d[i] = ref_sel;
               FN_IRQ:      pin_o_d[i] = irq_d;
               default:     pin_o_d[i] = 1'b0;
            endcase
            pin_oe_d[i] = (fn_q[i] != FN_INPUT) && (fn_q[i] != FN_OUT_EN);
            if ((fn_q[i] == FN_OUT_EN) && pin_s2_q[i])
               oen_d = 1'b1;
         end
      end

      // Reset input low forces state, flag, enable, pin drive and functions back; latched mode, rate and the register port are left alone
      if (!por_s2_q)
      begin
         state_d  = DEV_RESET;
         irq_d    = 1'b0;
         oen_d    = 1'b0;
         pin_oe_d = '0;
         pin_o_d  = '0;
         for (int i = 0; i < GPIO_N; i++)
            fn_d[i] = FN_INPUT;
      end
   end

   // Registers
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q  <= DEV_RESET;
         cnt_q    <= '0;
         mode_q   <= 1'b0;
         rate_q   <= 2'h0;
         irq_q    <= 1'b0;
         ack_q    <= 1'b0;
         rdata_q  <= '0;
         oen_q    <= 1'b0;
         pin_o_q  <= '0;
         pin_oe_q <= '0;
         for (int i = 0; i < GPIO_N; i++)
            fn_q[i] <= FN_INPUT;
      end
      else if (ce)
      begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         mode_q   <= mode_d;
         rate_q   <= rate_d;
         irq_q    <= irq_d;
         ack_q    <= ack_d;
         rdata_q  <= rdata_d;
         oen_q    <= oen_d;
         pin_o_q  <= pin_o_d;
         pin_oe_q <= pin_oe_d;
         fn_q     <= fn_d;
      end
   end

   // --------------------
   // Outputs
   // --------------------
   assign link.gpio_dev_o  = pin_o_q;
   assign link.gpio_dev_oe = pin_oe_q;
   assign link.reg_ack     = ack_q;
   assign link.reg_rdata   = rdata_q;
   assign host_mode_spi    = mode_q;
   assign clk_rate_sel     = rate_q;
   assign dev_ready        = (state_q == DEV_READY);
   assign out_enable       = oen_q;

endmodule
`default_nettype wire

// >>> rtl/rsc_host.sv
// Board end: drives the reset pulse and straps, then polls for ready.
// Software reaches it over Avalon-MM; pins from the device are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module rsc_host
   import rsc_pkg::*;
#(
   parameter int RST_HOLD_CYCLES    = RST_HOLD_CYC,
   parameter int ACCESS_WAIT_CYCLES = ACCESS_WAIT_CYC
)
(
   // Clock, reset, enable
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   // Avalon-MM slave
   input  wire logic [AV_AW-1:0]  avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   // Link
   rsc_if.host                    link
);

   // --------------------
   // Pin synchroniser
   // --------------------
   logic [GPIO_N-1:0] pin_s1_q;
   logic [GPIO_N-1:0] pin_s2_q;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end
      else if (ce)
      begin
         pin_s1_q <= link.gpio_level;
         pin_s2_q <= pin_s1_q;
      end
   end

   // --------------------
   // State
   // --------------------
   rsc_host_state_type state_q, state_d;
   logic [31:0]        cnt_q, cnt_d;
   logic [2:0]         strap_q, strap_d;
   logic               pend_q, pend_d;
   logic               cwr_q, cwr_d;
   logic [REG_AW-1:0]  caddr_q, caddr_d;
   logic [REG_DW-1:0]  cdata_q, cdata_d;
   logic [REG_DW-1:0]  rdat_q, rdat_d;
   logic               done_q, done_d;
   logic               avack_q, avack_d;
   logic [31:0]        avrd_q, avrd_d;

   // Next-state logic
   always_comb
   begin
      logic req;
      req     = avs_read | avs_write;
      state_d = state_q;
      cnt_d   = cnt_q + 32'h1;
      strap_d = strap_q;
      pend_d  = pend_q;
      cwr_d   = cwr_q;
      caddr_d = caddr_q;
      cdata_d = cdata_q;
      rdat_d  = rdat_q;
      done_d  = done_q;
      avack_d = req & ~avack_q;
      avrd_d  = avrd_q;

      // Avalon read data prepared in the waiting cycle
      if (req && !avack_q)
      begin
         avrd_d = '0;
         if (avs_address == AV_CTRL)
            avrd_d[CTRL_RATE +: 3] = strap_q;
         else if (avs_address == AV_STATUS)
         begin
            avrd_d[2:0]                = state_q;
            avrd_d[ST_READY]           = (state_q == H_READY) || (state_q == H_CMD_ACK);
            avrd_d[ST_GPIO +: GPIO_N]  = pin_s2_q;
         end
         else if (avs_address == AV_DEVDATA)
            avrd_d[DATA_DONE:0] = {done_q, rdat_q};
      end

      // Sequence
      case (state_q)
         H_IDLE:
            cnt_d = '0;
         H_RESET:
            if (cnt_q == 32'(RST_HOLD_CYCLES - 1))
            begin
               cnt_d   = '0;
               state_d = H_STRAP;
            end
         H_STRAP:
            if (cnt_q == 32'(ACCESS_WAIT_CYCLES - 1))
               state_d = H_POLL;
         H_POLL:
            state_d = H_POLL_ACK;
         H_POLL_ACK:
            if (link.reg_ack)
               state_d = link.reg_rdata[READY_BIT] ? H_READY : H_POLL;
         H_READY:
            if (pend_q)
            begin
               pend_d  = 1'b0;
               state_d = H_CMD_ACK;
            end
         H_CMD_ACK:
            if (link.reg_ack)
            begin
               rdat_d  = link.reg_rdata;
               done_d  = 1'b1;
               state_d = H_READY;
            end
         default:
            state_d = H_IDLE;
      endcase

      // Writes take effect on the edge after the wait ends, where waitrequest is sampled low
      if (avs_write && avack_q)
      begin
         if (avs_address == AV_CTRL)
         begin
            strap_d = avs_writedata[CTRL_RATE +: 3];
            if (avs_writedata[CTRL_START])
            begin
               state_d = H_RESET;
               cnt_d   = '0;
               pend_d  = 1'b0;
            end
         end
         else if ((avs_address == AV_DEVCMD) && (state_q == H_READY) && !pend_q)
         begin
            pend_d  = 1'b1;
            done_d  = 1'b0;
            cwr_d   = avs_writedata[CMD_WR];
            caddr_d = avs_writedata[CMD_ADDR +: REG_AW];
            cdata_d = avs_writedata[REG_DW-1:0];
         end
      end
   end

   // Registers
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= H_IDLE;
         cnt_q   <= '0;
         strap_q <= 3'h0;
         pend_q  <= 1'b0;
         cwr_q   <= 1'b0;
         caddr_q <= '0;
         cdata_q <= '0;
         rdat_q  <= '0;
         done_q  <= 1'b0;
         avack_q <= 1'b0;
         avrd_q  <= '0;
      end
      else if (ce)
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         strap_q <= strap_d;
         pend_q  <= pend_d;
         cwr_q   <= cwr_d;
         caddr_q <= caddr_d;
         cdata_q <= cdata_d;
         rdat_q  <= rdat_d;
         done_q  <= done_d;
         avack_q <= avack_d;
         avrd_q  <= avrd_d;
      end
   end

   // --------------------
   // Outputs
   // --------------------
   logic strapping;
   assign strapping = (state_q == H_RESET) || (state_q == H_STRAP);

   assign link.por_n = (state_q != H_IDLE) && (state_q != H_RESET);
   // Straps and the low pin 4 driven through reset and the hold window
   assign link.gpio_host_oe = strapping ?
          GPIO_N'((1 << PIN_RATE0) | (1 << PIN_RATE1) | (1 << PIN_MODE) | (1 << PIN_LOW))
          : '0;
   assign link.gpio_host_o  = strapping ?
          GPIO_N'((strap_q[2] << PIN_MODE) | (strap_q[1] << PIN_RATE1)
                  | (strap_q[0] << PIN_RATE0)) : '0;
   assign link.reg_req   = (state_q == H_POLL) || ((state_q == H_READY) && pend_q);
   assign link.reg_wr    = (state_q == H_READY) && cwr_q;
   assign link.reg_addr  = (state_q == H_POLL) ? REG_STATUS : caddr_q;
   assign link.reg_wdata = cdata_q;
   assign avs_waitrequest = (avs_read | avs_write) & ~avack_q;
   assign avs_readdata    = avrd_q;

endmodule
`default_nettype wire

// >>> tb/rsc_link_props.sv
// Concurrent checks on the link between the board end and the device end.
// Assumes one mclk domain; reset is the bench's active-low rst_n.
`timescale 1ns/1ps
`default_nettype none
module rsc_link_props
   import rsc_pkg::*;
#(
   parameter int RST_HOLD_CYCLES    = 20,
   parameter int ACCESS_WAIT_CYCLES = 200
)
(
   // Clock and reset
   input wire logic              mclk,
   input wire logic              rst_n,
   // Link signals
   input wire logic              por_n,
   input wire logic [GPIO_N-1:0] gpio_dev_oe,
   input wire logic [GPIO_N-1:0] gpio_host_oe,
   input wire logic [GPIO_N-1:0] gpio_level,
   input wire logic              reg_req,
   input wire logic              reg_ack
);
   // --------------------
   // Phase counters
   // --------------------
   int   low_cnt_q;
   int   low_cnt_d;
   int   high_cnt_q;
   int   high_cnt_d;
   logic armed_q;
   logic armed_d;

   // Armed only once por_n was high, so the reset-time low is not judged
   always_comb
   begin
      low_cnt_d  = por_n ? 0 : low_cnt_q + 1;
      high_cnt_d = por_n ? high_cnt_q + 1 : 0;
      armed_d    = armed_q | por_n;
   end

   // Counter registers
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         low_cnt_q  <= 0;
         high_cnt_q <= 0;
         armed_q    <= 1'b0;
      end
      else
      begin
         low_cnt_q  <= low_cnt_d;
         high_cnt_q <= high_cnt_d;
         armed_q    <= armed_d;
      end
   end

   // --------------------
   // Properties
   // --------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   property p_reset_frees_pins;
      (!por_n) [*4] |-> gpio_dev_oe == '0;
   endproperty
   a_reset_frees_pins: assert property (p_reset_frees_pins)
      else $error("device drives pins while held in reset");

   property p_reset_no_ack;
      (!por_n) [*4] |-> !reg_ack;
   endproperty
   a_reset_no_ack: assert property (p_reset_no_ack)
      else $error("device answers while held in reset");

   property p_reset_hold;
      $rose(por_n) && armed_q |-> low_cnt_q >= RST_HOLD_CYCLES;
   endproperty
   a_reset_hold: assert property (p_reset_hold)
      else $error("device reset pulse too short");

   property p_access_wait;
      reg_req |-> por_n && high_cnt_q >= ACCESS_WAIT_CYCLES;
   endproperty
   a_access_wait: assert property (p_access_wait)
      else $error("register request before access wait ran out");

   property p_ack_follows;
      reg_req |=> reg_ack ##1 !reg_ack;
   endproperty
   a_ack_follows: assert property (p_ack_follows)
      else $error("register answer not one cycle after request");

   property p_ack_asked;
      reg_ack |-> $past(reg_req);
   endproperty
   a_ack_asked: assert property (p_ack_asked)
      else $error("register answer without request");

   property p_strap_hold;
      $fell(gpio_host_oe[PIN_MODE]) |-> por_n && high_cnt_q >= ACCESS_WAIT_CYCLES;
   endproperty
   a_strap_hold: assert property (p_strap_hold)
      else $error("straps released too early");

   property p_pin4_low;
      gpio_host_oe[PIN_MODE] |-> !gpio_level[PIN_LOW];
   endproperty
   a_pin4_low: assert property (p_pin4_low)
      else $error("pin 4 not low while straps are held");

   property p_no_early_drive;
      $fell(por_n) |-> ##1 (gpio_dev_oe == $past(gpio_dev_oe)) or (gpio_dev_oe == '0);
   endproperty
   a_no_early_drive: assert property (p_no_early_drive)
      else $error("device starts driving pins as reset begins");
endmodule
`default_nettype wire

// >>> tb/tb_reset_and_strap_config.sv
// Bench joining the board end and the device end over the link.
// Assumes shortened counts; software side is an Avalon-MM master task.
`timescale 1ns/1ps
`default_nettype none
module tb_reset_and_strap_config
   import rsc_pkg::*;
;
   typedef struct packed {logic [31:0] exp; logic [31:0] mask;} rsc_note_type;
   localparam int HOLD = 20;
   localparam int WAIT = 200;
   logic         mclk = 1'b0;
   logic         rst_n = 1'b0;
   logic         ce = 1'b1;
   logic [3:0]   avs_address = 4'h0;
   logic         avs_read = 1'b0;
   logic         avs_write = 1'b0;
   logic         chk = 1'b0;
   logic [31:0]  avs_writedata = 32'h0;
   logic [31:0]  avs_readdata;
   logic         avs_waitrequest;
   logic         dpll_lock = 1'b0;
   logic         dpll_holdover = 1'b0;
   logic         ref_fail = 1'b0;
   logic         ref_sel = 1'b0;
   logic         status_change = 1'b0;
   logic         host_mode_spi;
   logic [1:0]   clk_rate_sel;
   logic         dev_ready;
   logic         out_enable;
   logic [1:0]   rate;
   logic         mode;
   logic [31:0]  q;
   logic [31:0]  rnd;
   int           seed = 32'h05c8fee5;
   int           mismatches = 0;
   int           comparisons = 0;
   int           cycles = 0;
   rsc_note_type notes[$];
   rsc_note_type n;

   // Clock
   always #5 mclk = ~mclk;

   // --------------------
   // Design and checker
   // --------------------
   rsc_if link_if ();
   rsc_host #(.RST_HOLD_CYCLES(HOLD), .ACCESS_WAIT_CYCLES(WAIT)) rsc_host_i (
      .mclk(mclk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link(link_if));
   rsc_device #(.CFG_SAMPLE_CYCLES(100)) rsc_device_i (
      .mclk(mclk), .rst_n(rst_n), .ce(ce), .link(link_if), .dpll_lock(dpll_lock),
      .dpll_holdover(dpll_holdover), .ref_fail(ref_fail), .ref_sel(ref_sel),
      .status_change(status_change), .host_mode_spi(host_mode_spi),
      .clk_rate_sel(clk_rate_sel), .dev_ready(dev_ready), .out_enable(out_enable));
   rsc_link_props #(.RST_HOLD_CYCLES(HOLD), .ACCESS_WAIT_CYCLES(WAIT)) rsc_link_props_i (
      .mclk(mclk), .rst_n(rst_n), .por_n(link_if.por_n), .gpio_dev_oe(link_if.gpio_dev_oe),
      .gpio_host_oe(link_if.gpio_host_oe), .gpio_level(link_if.gpio_level),
      .reg_req(link_if.reg_req), .reg_ack(link_if.reg_ack));

   // --------------------
   // Tasks
   // --------------------
   task automatic stop_test();
      $display("TB: mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One Avalon transfer; request held until waitrequest is sampled low
   task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] d,
                     input logic c, output logic [31:0] r);
      @(posedge mclk);
      avs_read      <= rd;
      avs_write     <= ~rd;
      avs_address   <= a;
      avs_writedata <= d;
      chk           <= c;
      do
         @(posedge mclk);
      while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      chk       <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] mask);
      logic [31:0] r;
      notes.push_back('{exp, mask});
      av(1'b1, a, 32'h0, 1'b1, r);
   endtask

   // Poll board state until it is back in its ready state
   task automatic wait_ready();
      logic [31:0] r;
      int          k;
      k = 0;
      do
      begin
         av(1'b1, AV_STATUS, 32'h0, 1'b0, r);
         k++;
      end
      while (r[2:0] !== 3'h5 && k < 3000);
   endtask

   task automatic dev_cmd(input logic wr, input logic [8:0] a, input logic [7:0] d);
      logic [31:0] r;
      av(1'b0, AV_DEVCMD, {7'h0, wr, 7'h0, a, d}, 1'b0, r);
      wait_ready();
   endtask

   // --------------------
   // Read monitor, random inputs, timeout
   // --------------------
   always @(posedge mclk)
   begin
      if (avs_read && avs_waitrequest === 1'b0 && chk)
      begin
         n = notes.size() > 0 ? notes.pop_front() : rsc_note_type'{32'hdead, 32'hffffffff};
         check("avs_readdata", avs_readdata & n.mask, n.exp);
      end
   end

   // Unused loop status lines still toggle so nothing rests at one level
   always @(posedge mclk)
   begin
      rnd = $random(seed);
      dpll_holdover <= rnd[0];
      ref_fail      <= rnd[1];
      ref_sel       <= rnd[2];
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         stop_test();
      end
   end

   // --------------------
   // Main sequence
   // --------------------
   initial
   begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      rd_chk(4'h2, 32'h0, 32'hffffffff);
      for (int k = 0; k < 8; k++)
      begin
         rate = k[1:0];
         mode = k[2];
         av(1'b0, AV_CTRL, {28'h0, mode, rate, 1'b1}, 1'b0, q);
         repeat (6) @(posedge mclk);
         check("dev_ready_reset", {31'h0, dev_ready}, 32'h0);
         wait_ready();
         rd_chk(AV_STATUS, 32'hd, 32'hf);
         check("dev_ready", {31'h0, dev_ready}, 32'h1);
         check("clk_rate_sel", {30'h0, clk_rate_sel}, {30'h0, rate});
         check("host_mode_spi", {31'h0, host_mode_spi}, {31'h0, mode});
         dev_cmd(1'b0, REG_STATUS, 8'h0);
         rd_chk(AV_DEVDATA, {23'h0, 1'b1, 1'b1, 1'b0, 3'h0, mode, rate}, 32'h1ff);
         dev_cmd(1'b1, REG_FN_BASE, {5'h0, FN_LOCK});
         // Strap pin reused as lock output; latched rate must not move
         for (int j = 0; j < 3; j++)
         begin
            @(posedge mclk);
            rnd = $random(seed);
            dpll_lock <= rnd[0];
            repeat (6) @(posedge mclk);
            check("lock_pin", {31'h0, link_if.gpio_level[PIN_RATE0]}, {31'h0, dpll_lock});
            check("rate_held", {30'h0, clk_rate_sel}, {30'h0, rate});
         end
      end
      // Status event raises the pending flag, a read clears it
      @(posedge mclk);
      status_change <= 1'b1;
      @(posedge mclk);
      status_change <= 1'b0;
      dev_cmd(1'b0, REG_STATUS, 8'h0);
      rd_chk(AV_DEVDATA, 32'h1c7, 32'h1ff);
      dev_cmd(1'b0, REG_STATUS, 8'h0);
      rd_chk(AV_DEVDATA, 32'h187, 32'h1ff);
      // Pin 6 rests at its pull-up, so as enable input it reads high
      dev_cmd(1'b1, 9'h016, {5'h0, FN_OUT_EN});
      repeat (6) @(posedge mclk);
      check("out_enable", {31'h0, out_enable}, 32'h1);
      stop_test();
   end
endmodule
`default_nettype wire
